/* core/filter_chain_pkg.sv */
// Purpose: Shared constants and types of the audio filter chain
// Assumes: 16-bit stereo samples, coefficients scaled by 2^13
// Notes:   Register map indices are word addresses on the plain port
package filter_chain_pkg;

	// ============================================================
	// Widths
	localparam int SAMPLE_W   = 16;
	localparam int COEF_W     = 16;
	localparam int NARROW_W   = 14;
	localparam int CEXT_W     = 17;
	localparam int FRAC_BITS  = 13;
	localparam int ACC_W      = 24;
	localparam int ADDR_W     = 6;
	localparam int DATA_W     = 16;
	localparam int NUM_STAGES = 5;
	localparam int NUM_BANDS  = 5;
	localparam int NUM_COEF   = 24;

	// ============================================================
	// Register map
	localparam logic [ADDR_W-1:0] ADDR_PATH       = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE     = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_COEF_BASE  = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 6'h1a;

	// Coefficient slots, offset from ADDR_COEF_BASE
	localparam logic [4:0] CI_HP_A   = 5'h00;
	localparam logic [4:0] CI_HP_B   = 5'h01;
	localparam logic [4:0] CI_LP_A   = 5'h02;
	localparam logic [4:0] CI_LP_B   = 5'h03;
	localparam logic [4:0] CI_SEP_A  = 5'h04;
	localparam logic [4:0] CI_SEP_B  = 5'h05;
	localparam logic [4:0] CI_GC_A   = 5'h06;
	localparam logic [4:0] CI_GC_B   = 5'h07;
	localparam logic [4:0] CI_GC_C   = 5'h08;
	localparam logic [4:0] CI_BAND   = 5'h09;

	// ============================================================
	// Reset values
	localparam logic [4:0]  PATH_RESET  = 5'h00;
	localparam logic [12:0] EN_RESET    = 13'h0000;
	localparam logic [15:0] COEF_RESET  = 16'h0000;

	// Coarse gain shifts: x4 is +12 dB, x16 is +24 dB
	localparam logic [2:0] SHIFT_12DB = 3'h2;
	localparam logic [2:0] SHIFT_24DB = 3'h4;

	// ============================================================
	// Types
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} stereo_t;

	typedef struct packed {
		logic loop_through;
		logic filter_on_playback_sel;
		logic dac_power;
		logic right_adc_power;
		logic left_adc_power;
	} path_cfg_t;

	typedef struct packed {
		logic [4:0] band_enable;
		logic [1:0] coarse_gain_sel;
		logic       gain_comp_eq_enable;
		logic       separation_type_sel;
		logic       separation_enable;
		logic       lowpass_enable;
		logic       second_highpass_enable;
		logic       first_highpass_enable;
	} filter_en_t;

endpackage : filter_chain_pkg

/* core/first_order_stage.sv */
// Purpose: One filter section, y = (a*x + c*x1 - b*y1) / 2^13
// Assumes: Coefficients already sign extended to the common width
// Notes:   Purely combinational; state is held by the caller
`timescale 1ns/1ps
`default_nettype none
module first_order_stage
	import filter_chain_pkg::*;
#(
	parameter int W  = ACC_W,
	parameter int CW = CEXT_W
) (
	// Samples
	input  wire logic signed [W-1:0]  x,
	input  wire logic signed [W-1:0]  x1,
	input  wire logic signed [W-1:0]  y1,
	// Coefficients
	input  wire logic signed [CW-1:0] a,
	input  wire logic signed [CW-1:0] b,
	input  wire logic signed [CW-1:0] c,
	// Result
	output logic signed [W-1:0]       y
);

	localparam int PW = W + CW + 2;

	logic signed [PW-1:0] prod_a;
	logic signed [PW-1:0] prod_b;
	logic signed [PW-1:0] prod_c;
	logic signed [PW-1:0] sum;

	// ============================================================
	// Multiply and accumulate
	assign prod_a = PW'(a) * PW'(x);
	assign prod_b = PW'(b) * PW'(y1);
	assign prod_c = PW'(c) * PW'(x1);
	assign sum    = prod_a + prod_c - prod_b;
	assign y      = W'(sum >>> FRAC_BITS);

endmodule : first_order_stage
`default_nettype wire

/* core/audio_filter_chain_path_select.sv */
// Purpose: Programmable filter chain with record/playback path select
// Assumes: Samples arrive as one-cycle strobes on the system clock
// Notes:   Whole chain is evaluated in the strobe cycle
//
// Overview of operation
// - Record path when playback select low, ADC on
// - Playback path when select high or ADCs off
// - Select high forces record data low
// - Loop-through with DAC on closes both switches on the record path
// - Two cascaded first-order high-pass stages
// - High-pass stages share 14-bit coefficient pair
// - Disabled stage passes samples at unity gain
// - First-order low-pass with own enable
// - Separation stage: high-pass or low-pass select
// - Disabled separation stage forwards unity gain
// - Gain equalizer with 16/14/16-bit coefficients
// - Coarse gain 0, +12 or +24 dB
// - Gain block transparent only when fully off
// - Five independently enabled band equalizers
// - Band biquads summed onto the input
// - Coefficients are two's complement, scaled 2^13
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module audio_filter_chain_path_select
	import filter_chain_pkg::*;
(
	// Clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST_B,
	// Register port
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	// Converter side samples
	input  wire stereo_t           ADC_SAMPLE,
	input  wire logic              ADC_VALID,
	input  wire stereo_t           DAC_SAMPLE,
	input  wire logic              DAC_VALID,
	// Path outputs
	output stereo_t                SERIAL_ADC_OUT,
	output logic                   REC_VALID,
	output stereo_t                PLAY_SAMPLE,
	output logic                   PLAY_VALID,
	output logic                   RECORD_PATH_SWITCH,
	output logic                   PLAYBACK_PATH_SWITCH
);

	// ============================================================
	// Functions
	function automatic logic coef_narrow(input logic [4:0] idx);
		coef_narrow = (idx <= CI_SEP_B) || (idx == CI_GC_B);
	endfunction : coef_narrow

	function automatic logic signed [CEXT_W-1:0] coef_val(
		input logic [COEF_W-1:0] raw,
		input logic              narrow);
		if (narrow)
			coef_val = {{3{raw[NARROW_W-1]}}, raw[NARROW_W-1:0]};
		else
			coef_val = {raw[COEF_W-1], raw};
	endfunction : coef_val

	function automatic logic signed [SAMPLE_W-1:0] sat16(
		input logic signed [ACC_W-1:0] v);
		if (v > ACC_W'(32767))
			sat16 = 16'sh7fff;
		else if (v < -ACC_W'(32768))
			sat16 = 16'sh8000;
		else
			sat16 = v[SAMPLE_W-1:0];
	endfunction : sat16

	// ============================================================
	// Registers
	path_cfg_t          path_reg;
	filter_en_t         en_reg;
	logic [COEF_W-1:0]  coef_reg [NUM_COEF];
	logic [DATA_W-1:0]  rdata_reg;
	logic               rec_sw_reg;
	logic               play_sw_reg;
	stereo_t            rec_out_reg;
	stereo_t            play_out_reg;
	logic               rec_valid_reg;
	logic               play_valid_reg;

	logic               adc_any;
	logic               rec_sw_next;
	logic               play_sw_next;
	logic               loop_mode;
	logic               is_coef;
	logic [4:0]         cidx;
	logic [ADDR_W-1:0]  coef_off;
	logic [DATA_W-1:0]  wr_masked;
	logic [DATA_W-1:0]  rd_word;
	logic               run;
	stereo_t            chain_in;
	stereo_t            chain_out;
	logic [2:0]         gain_shift;

	logic signed [CEXT_W-1:0] cval    [NUM_COEF];
	logic signed [CEXT_W-1:0] stage_a [NUM_STAGES];
	logic signed [CEXT_W-1:0] stage_b [NUM_STAGES];
	logic signed [CEXT_W-1:0] stage_c [NUM_STAGES];
	logic                     stage_en[NUM_STAGES];

	// ============================================================
	// Path select
	assign adc_any      = path_reg.left_adc_power | path_reg.right_adc_power;
	assign rec_sw_next  = !path_reg.filter_on_playback_sel & adc_any;
	assign loop_mode    = path_reg.loop_through & path_reg.dac_power
		& rec_sw_next;
	assign play_sw_next = path_reg.filter_on_playback_sel | !adc_any
		| loop_mode;
	assign chain_in     = rec_sw_next ? ADC_SAMPLE : DAC_SAMPLE;
	assign run          = rec_sw_next ? ADC_VALID : DAC_VALID;

	// ============================================================
	// Register port decode
	assign coef_off  = REG_ADDR - ADDR_COEF_BASE;
	assign cidx      = coef_off[4:0];
	assign is_coef   = (REG_ADDR >= ADDR_COEF_BASE)
		&& (coef_off < ADDR_W'(NUM_COEF));
	assign wr_masked = coef_narrow(cidx)
		? {2'h0, REG_WDATA[NARROW_W-1:0]} : REG_WDATA;
	assign rd_word   = (REG_ADDR == ADDR_PATH)   ? DATA_W'(path_reg) :
		(REG_ADDR == ADDR_ENABLE) ? DATA_W'(en_reg) :
		is_coef ? coef_reg[cidx] :
		(REG_ADDR == ADDR_STATUS) ? {14'h0, play_sw_reg, rec_sw_reg} :
		16'h0000;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			path_reg  <= path_cfg_t'(PATH_RESET);
			en_reg    <= filter_en_t'(EN_RESET);
			rdata_reg <= 16'h0000;
			for (int i = 0; i < NUM_COEF; i++)
				coef_reg[i] <= COEF_RESET;
		end else begin
			rdata_reg <= REG_RD ? rd_word : 16'h0000;
			if (REG_WR && REG_ADDR == ADDR_PATH)
				path_reg <= path_cfg_t'(REG_WDATA[4:0]);
			if (REG_WR && REG_ADDR == ADDR_ENABLE)
				en_reg <= filter_en_t'(REG_WDATA[12:0]);
			if (REG_WR && is_coef)
				coef_reg[cidx] <= wr_masked;
		end
	end

	// ============================================================
	// Coefficient fan-out, shared by both channels
	for (genvar i = 0; i < NUM_COEF; i++) begin : g_cval
		assign cval[i] = coef_val(coef_reg[i], coef_narrow(5'(i)));
	end

	for (genvar s = 0; s < 2; s++) begin : g_hp
		assign stage_a[s] = cval[CI_HP_A];
		assign stage_b[s] = cval[CI_HP_B];
		assign stage_c[s] = -cval[CI_HP_A];
	end
	assign stage_en[0] = en_reg.first_highpass_enable;
	assign stage_en[1] = en_reg.second_highpass_enable;
	assign stage_a[2]  = cval[CI_LP_A];
	assign stage_b[2]  = cval[CI_LP_B];
	assign stage_c[2]  = cval[CI_LP_A];
	assign stage_en[2] = en_reg.lowpass_enable;
	assign stage_a[3]  = cval[CI_SEP_A];
	assign stage_b[3]  = cval[CI_SEP_B];
	assign stage_c[3]  = en_reg.separation_type_sel
		? cval[CI_SEP_A] : -cval[CI_SEP_A];
	assign stage_en[3] = en_reg.separation_enable;
	assign stage_a[4]  = cval[CI_GC_A];
	assign stage_b[4]  = cval[CI_GC_B];
	assign stage_c[4]  = cval[CI_GC_C];
	assign stage_en[4] = en_reg.gain_comp_eq_enable;
	assign gain_shift  = en_reg.coarse_gain_sel[1] ? SHIFT_24DB :
		en_reg.coarse_gain_sel[0] ? SHIFT_12DB : 3'h0;

	// ============================================================
	// Per-channel filter state and datapath
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic signed [ACC_W-1:0] xin_reg [NUM_STAGES];
		logic signed [ACC_W-1:0] yflt_reg[NUM_STAGES];
		logic signed [ACC_W-1:0] bx1_reg;
		logic signed [ACC_W-1:0] bx2_reg;
		logic signed [ACC_W-1:0] h1_reg  [NUM_BANDS];
		logic signed [ACC_W-1:0] h2_reg  [NUM_BANDS];
		logic signed [ACC_W-1:0] s_in    [NUM_STAGES+1];
		logic signed [ACC_W-1:0] s_flt   [NUM_STAGES];
		logic signed [ACC_W-1:0] bx;
		logic signed [ACC_W-1:0] bdiff;
		logic signed [ACC_W-1:0] h       [NUM_BANDS];
		logic signed [ACC_W-1:0] acc     [NUM_BANDS+1];
		logic signed [ACC_W-1:0] gc_pre;

		assign s_in[0] = ACC_W'(ch == 0 ? chain_in.left : chain_in.right);

		for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
			first_order_stage #(.W(ACC_W), .CW(CEXT_W)) u_stage (
				.x  (s_in[s]),
				.x1 (xin_reg[s]),
				.y1 (yflt_reg[s]),
				.a  (stage_a[s]),
				.b  (stage_b[s]),
				.c  (stage_c[s]),
				.y  (s_flt[s])
			);
			if (s < NUM_STAGES-1) begin : g_pass
				assign s_in[s+1] = stage_en[s] ? s_flt[s] : s_in[s];
			end
		end

		assign gc_pre = stage_en[4] ? s_flt[4] : s_in[4];
		assign s_in[NUM_STAGES] = gc_pre <<< gain_shift;
		assign bx     = s_in[NUM_STAGES];
		assign bdiff  = bx - bx2_reg;
		assign acc[0] = bx;

		for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
			first_order_stage #(.W(ACC_W), .CW(CEXT_W)) u_band (
				.x  (bdiff),
				.x1 (h1_reg[b]),
				.y1 (h2_reg[b]),
				.a  (cval[CI_BAND + 5'(3*b)]),
				.b  (-cval[CI_BAND + 5'(3*b+2)]),
				.c  (cval[CI_BAND + 5'(3*b+1)]),
				.y  (h[b])
			);
			assign acc[b+1] = acc[b]
				+ (en_reg.band_enable[b] ? h[b] : ACC_W'(0));
		end

		always_ff @(posedge SYS_CLK or negedge RST_B) begin
			if (!RST_B) begin
				bx1_reg <= '0;
				bx2_reg <= '0;
				for (int k = 0; k < NUM_STAGES; k++) begin
					xin_reg[k]  <= '0;
					yflt_reg[k] <= '0;
				end
				for (int k = 0; k < NUM_BANDS; k++) begin
					h1_reg[k] <= '0;
					h2_reg[k] <= '0;
				end
			end else if (run) begin
				bx1_reg <= bx;
				bx2_reg <= bx1_reg;
				for (int k = 0; k < NUM_STAGES; k++) begin
					xin_reg[k]  <= s_in[k];
					yflt_reg[k] <= s_flt[k];
				end
				for (int k = 0; k < NUM_BANDS; k++) begin
					h1_reg[k] <= h[k];
					h2_reg[k] <= h1_reg[k];
				end
			end
		end

		if (ch == 0) begin : g_l
			assign chain_out.left = sat16(acc[NUM_BANDS]);
		end else begin : g_r
			assign chain_out.right = sat16(acc[NUM_BANDS]);
		end

		hp_bypass_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
			!stage_en[0] && !stage_en[1] |-> s_in[2] == s_in[0])
			else $error("High-pass bypass altered the sample");
		band_sum_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
			en_reg.band_enable == 5'h00 |-> acc[NUM_BANDS] == bx)
			else $error("Band block not transparent with bands off");
	end

	// ============================================================
	// Outputs
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rec_sw_reg     <= 1'b0;
			play_sw_reg    <= 1'b0;
			rec_out_reg    <= '0;
			play_out_reg   <= '0;
			rec_valid_reg  <= 1'b0;
			play_valid_reg <= 1'b0;
		end else begin
			rec_sw_reg     <= rec_sw_next;
			play_sw_reg    <= play_sw_next;
			rec_valid_reg  <= ADC_VALID;
			play_valid_reg <= loop_mode ? ADC_VALID : DAC_VALID;
			if (ADC_VALID || path_reg.filter_on_playback_sel)
				rec_out_reg <= path_reg.filter_on_playback_sel ? '0 :
					rec_sw_next ? chain_out : ADC_SAMPLE;
			if (loop_mode ? ADC_VALID : DAC_VALID)
				play_out_reg <= play_sw_next ? chain_out : DAC_SAMPLE;
		end
	end

	assign REG_RDATA            = rdata_reg;
	assign SERIAL_ADC_OUT       = rec_out_reg;
	assign REC_VALID            = rec_valid_reg;
	assign PLAY_SAMPLE          = play_out_reg;
	assign PLAY_VALID           = play_valid_reg;
	assign RECORD_PATH_SWITCH   = rec_sw_reg;
	assign PLAYBACK_PATH_SWITCH = play_sw_reg;

	// ============================================================
	// Checks
	rec_switch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		!path_reg.filter_on_playback_sel && adc_any
		|=> RECORD_PATH_SWITCH)
		else $error("Record switch open in recording mode");
	play_switch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		path_reg.filter_on_playback_sel || !adc_any
		|=> PLAYBACK_PATH_SWITCH && !RECORD_PATH_SWITCH)
		else $error("Playback switch wrong in playback mode");
	adc_low_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		path_reg.filter_on_playback_sel && ADC_VALID
		|=> SERIAL_ADC_OUT == '0 && REC_VALID)
		else $error("Record data not low under playback select");
	loop_both_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		path_reg.loop_through && path_reg.dac_power && adc_any
		&& !path_reg.filter_on_playback_sel
		|=> RECORD_PATH_SWITCH && PLAYBACK_PATH_SWITCH)
		else $error("Loop-through did not close both switches");
	chain_bypass_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		en_reg == filter_en_t'(EN_RESET) |-> chain_out == chain_in)
		else $error("Disabled chain is not transparent");
	coarse_gain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		en_reg.coarse_gain_sel[1] && !en_reg.gain_comp_eq_enable
		|-> g_ch[0].bx == (g_ch[0].s_in[4] <<< 4))
		else $error("Coarse gain +24 dB not a shift by four");
	sample_rate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		ADC_VALID && rec_sw_next && !loop_mode
		|=> REC_VALID && SERIAL_ADC_OUT == $past(chain_out))
		else $error("Filtered record sample not delivered next cycle");

endmodule : audio_filter_chain_path_select
`default_nettype wire

/* verification/sample_source.sv */
// Purpose: Converter-side sample source for the filter chain bench
// Assumes: One strobe per request, system clock domain
// Notes:   Data outside the strobe is scrambled every cycle
`timescale 1ns/1ps
`default_nettype none
module sample_source
	import filter_chain_pkg::*;
(
	// Clock and reset
	input  wire logic    clk,
	input  wire logic    rst_b,
	// Request from the bench
	input  wire logic    go,
	input  wire stereo_t data,
	// Sample stream
	output stereo_t      sample,
	output logic         valid
);
	// ============================================================
	// Sample launch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			valid  <= 1'b0;
			sample <= '0;
		end else if (go) begin
			valid  <= 1'b1;
			sample <= data;
		end else begin
			valid  <= 1'b0;
			sample <= ~sample;
		end
	end
endmodule : sample_source
`default_nettype wire

/* verification/tb_audio_filter_chain_path_select.sv */
// Purpose: Self-checking bench of the filter chain and path select
// Assumes: Unit and half coefficients with zero feedback, small samples
// Notes:   Expected values queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module tb_audio_filter_chain_path_select
	import filter_chain_pkg::*;
;
	// ============================================================
	// Signals
	logic              SYS_CLK, RST_B, REG_WR, REG_RD, rd_d;
	logic [ADDR_W-1:0] REG_ADDR;
	logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
	logic              adc_go, dac_go, ADC_VALID, DAC_VALID;
	logic              REC_VALID, PLAY_VALID;
	logic              RECORD_PATH_SWITCH, PLAYBACK_PATH_SWITCH;
	stereo_t           adc_data, dac_data, ADC_SAMPLE, DAC_SAMPLE;
	stereo_t           SERIAL_ADC_OUT, PLAY_SAMPLE;
	int                n_fail, checked;
	logic [31:0]       rec_q[$], play_q[$];
	logic [15:0]       rd_q[$];
	int                p1[2], p2[2];

	localparam logic [4:0]  PATHS [8] = '{5'h03, 5'h01, 5'h02, 5'h04,
		5'h0f, 5'h17, 5'h15, 5'h16};
	localparam logic [15:0] STAT [8] = '{16'h1, 16'h1, 16'h1, 16'h2,
		16'h2, 16'h3, 16'h3, 16'h3};
	localparam logic [15:0] ENS [11] = '{16'h0001, 16'h0002, 16'h0004,
		16'h0008, 16'h0018, 16'h0000, 16'h0040, 16'h0080, 16'h00c0,
		16'h1100, 16'h0020};
	localparam int MODES [11] = '{1, 1, 2, 6, 2, 0, 3, 4, 4, 5, 2};

	// ============================================================
	// Design and converter models
	audio_filter_chain_path_select u_audio_filter_chain_path_select (
		.SYS_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
		.REG_RDATA, .ADC_SAMPLE, .ADC_VALID, .DAC_SAMPLE, .DAC_VALID,
		.SERIAL_ADC_OUT, .REC_VALID, .PLAY_SAMPLE, .PLAY_VALID,
		.RECORD_PATH_SWITCH, .PLAYBACK_PATH_SWITCH);
	sample_source u_sample_source_adc (.clk(SYS_CLK), .rst_b(RST_B),
		.go(adc_go), .data(adc_data), .sample(ADC_SAMPLE),
		.valid(ADC_VALID));
	sample_source u_sample_source_dac (.clk(SYS_CLK), .rst_b(RST_B),
		.go(dac_go), .data(dac_data), .sample(DAC_SAMPLE),
		.valid(DAC_VALID));

	always #20 SYS_CLK = ~SYS_CLK;

	// ============================================================
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
		end
	endtask : check

	task complete_run;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task reg_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
		@(posedge SYS_CLK);
	endtask : reg_wr

	task reg_rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
		rd_q.push_back(exp);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		@(posedge SYS_CLK);
	endtask : reg_rd

	function automatic int calc(input int mode, input int x,
		input int a1, input int a2);
		case (mode)
			1: return a1 - x;
			2: return (x + a1) >>> 1;
			3: return x <<< 2;
			4: return x <<< 4;
			5: return 3 * x - 2 * a2;
			6: return (x - a1) >>> 1;
			default: return x;
		endcase
	endfunction : calc

	// Kind: 0 record, 1 playback on DAC, 2 muted ADC, 3 loop-through
	task automatic send(input int kind, input int mode);
		int      x[2];
		int      e[2];
		stereo_t s;
		stereo_t ex;
		for (int c = 0; c < 2; c++) begin
			x[c] = int'($urandom_range(4000)) - 2000;
			e[c] = calc(mode, x[c], p1[c], p2[c]);
		end
		s  = {x[0][15:0], x[1][15:0]};
		ex = (kind == 2) ? '0 : {e[0][15:0], e[1][15:0]};
		if (kind != 1)
			rec_q.push_back(ex);
		if (kind == 1 || kind == 3)
			play_q.push_back(ex);
		if (kind != 2) begin
			p2 = p1;
			p1 = x;
		end
		if (kind == 1) begin
			dac_data <= s;
			dac_go   <= 1'b1;
		end else begin
			adc_data <= s;
			adc_go   <= 1'b1;
		end
		@(posedge SYS_CLK);
		adc_go <= 1'b0;
		dac_go <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
	endtask : send

	task drain;
		int n;
		n = 0;
		while (rec_q.size() + play_q.size() + rd_q.size() != 0 && n < 50)
		begin
			@(posedge SYS_CLK);
			n++;
		end
		if (n >= 50) begin
			n_fail++;
			$display("[ERR] queues exp=empty seen=pending");
			complete_run;
		end
	endtask : drain

	// ============================================================
	// Output monitor
	always @(posedge SYS_CLK) begin
		rd_d <= REG_RD;
		if (REC_VALID === 1'b1) begin
			if (rec_q.size() == 0) check("rec_extra", 32'h1, 32'h0);
			else check("rec", SERIAL_ADC_OUT, rec_q.pop_front());
		end
		if (PLAY_VALID === 1'b1) begin
			if (play_q.size() == 0) check("play_extra", 32'h1, 32'h0);
			else check("play", PLAY_SAMPLE, play_q.pop_front());
		end
		if (rd_d === 1'b1 && rd_q.size() != 0)
			check("rdata", {16'h0, REG_RDATA}, {16'h0, rd_q.pop_front()});
	end

	// ============================================================
	// Main sequence
	initial begin
		SYS_CLK = 0; RST_B = 0; REG_ADDR = '0; REG_WDATA = '0;
		REG_WR = 0; REG_RD = 0; adc_go = 0; dac_go = 0;
		adc_data = '0; dac_data = '0; n_fail = 0; checked = 0;
		p1 = '{0, 0};
		p2 = '{0, 0};
		void'($urandom(86));
		repeat (12) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		check("rec_sw", {31'h0, RECORD_PATH_SWITCH}, 32'h0);
		check("play_sw", {31'h0, PLAYBACK_PATH_SWITCH}, 32'h1);
		@(posedge SYS_CLK);
		for (int i = 0; i < 8; i++) begin
			reg_wr(ADDR_PATH, {11'h0, PATHS[i]});
			reg_rd(ADDR_STATUS, STAT[i]);
		end
		reg_wr(ADDR_COEF_BASE, 16'hffff);
		reg_rd(ADDR_COEF_BASE, 16'h3fff);
		reg_wr(6'h08, 16'h8001);
		reg_rd(6'h08, 16'h8001);
		reg_rd(6'h3f, 16'h0000);
		reg_wr(ADDR_COEF_BASE, 16'h2000);
		reg_wr(6'h04, 16'h1000);
		reg_wr(6'h06, 16'h1000);
		reg_wr(6'h0b, 16'h2000);
		reg_wr(6'h17, 16'h2000);
		reg_wr(6'h08, 16'h1000);
		reg_wr(6'h0a, 16'h1000);
		reg_wr(ADDR_PATH, 16'h000f);
		repeat (2) send(2, 0);
		repeat (2) send(1, 0);
		reg_wr(ADDR_PATH, 16'h0003);
		for (int i = 0; i < 11; i++) begin
			reg_wr(ADDR_ENABLE, ENS[i]);
			repeat (4) send(0, MODES[i]);
			reg_wr(ADDR_ENABLE, 16'h0000);
			repeat (2) send(0, 0);
		end
		reg_wr(ADDR_PATH, 16'h0017);
		repeat (2) send(3, 0);
		drain;
		complete_run;
	end
endmodule : tb_audio_filter_chain_path_select
`default_nettype wire
